// >>> aas_sequencer.sv
// Functional notes
// - no frame before host arm command
// - disarm while waiting ends capture immediately
// - disarm mid-line: finish line, send partial
// - run style: one-image or repeating
// - one-image: one frame then self disarm
// - repeating: frame per suitable triggers
// - repeating: armed until disarm command
// - one-image: setup cycle before each frame
// - arm trigger on (repeating only): wait, ignore frame triggers
// - arm trigger moves to wait-frame
// - frame trigger moves to wait-line
// - count frames, back to wait-arm
// - frames-per-arm from 1 to 65535
// - arm trigger off: generated internally
// - origin: host command or lines 1-3
// - line origin: rising or falling edge
// - line triggers only while frame valid
// - frame valid until enough lines acquired
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "aas_params.svh"
module aas_sequencer (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [2:0]  trig_line_in,
	input  wire logic        frame_start_trig,
	input  wire logic        line_start_trig,
	input  wire logic        line_done,
	input  wire logic        frame_lines_done,
	output logic             frame_valid,
	output logic             line_expose_start,
	output logic             partial_frame_send,
	output logic             armed,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ****************************************
	// edge detector for line origins
	// ****************************************
	aas_edge_if eif ();
	aas_edge_det u_edge (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.line_in (trig_line_in),
		.eif     (eif)
	);
	// ****************************************
	// bus slave state
	// ****************************************
	logic [4:0]  ctrl_reg;
	logic [4:0]  ctrl_next;
	logic [15:0] fcount_reg;
	logic [15:0] fcount_next;
	logic [15:0] setup_reg;
	logic [15:0] setup_next;
	logic        aw_got_reg;
	logic        aw_got_next;
	logic        w_got_reg;
	logic        w_got_next;
	logic [7:0]  aw_addr_reg;
	logic [7:0]  aw_addr_next;
	logic [31:0] w_data_reg;
	logic [31:0] w_data_next;
	logic [3:0]  w_strb_reg;
	logic [3:0]  w_strb_next;
	logic        bvalid_reg;
	logic        bvalid_next;
	logic [1:0]  bresp_reg;
	logic [1:0]  bresp_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [1:0]  rresp_reg;
	logic [1:0]  rresp_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        cmd_arm;
	logic        cmd_disarm;
	logic        cmd_host;
	logic        wr_fire;
	// ****************************************
	// sequencer state
	// ****************************************
	aas_pkg::aas_state_t st_reg;
	aas_pkg::aas_state_t st_next;
	logic [15:0] fdone_reg;
	logic [15:0] fdone_next;
	logic [15:0] setup_cnt_reg;
	logic [15:0] setup_cnt_next;
	logic        stop_pend_reg;
	logic        stop_pend_next;
	logic        fv_reg;
	logic        fv_next;
	logic        lx_reg;
	logic        lx_next;
	logic        pf_reg;
	logic        pf_next;
	logic        armed_reg;
	logic        armed_next;
	logic        arm_trig;
	logic        one_image;
	logic        use_trig;
	logic [15:0] fcount_eff;
	assign one_image = ~ctrl_reg[`AAS_CTRL_STYLE];
	assign use_trig  = ctrl_reg[`AAS_CTRL_USE];
	assign eif.origin  = ctrl_reg[`AAS_CTRL_ORG_HI:`AAS_CTRL_ORG_LO];
	assign eif.falling = ctrl_reg[`AAS_CTRL_EDGE];
	// host command or synced line edge
	assign arm_trig = (eif.origin == 2'(aas_pkg::aas_org_host)) ? cmd_host : eif.fire;
	// zero is not a legal count; treat it as one so the counter can never run away
	assign fcount_eff = (fcount_reg == 16'h0000) ? 16'h0001 : fcount_reg;
	assign wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
	assign cmd_arm    = wr_fire & (aw_addr_reg == `AAS_OFF_CMD) & w_strb_reg[0] & w_data_reg[`AAS_CMD_ARM];
	assign cmd_disarm = wr_fire & (aw_addr_reg == `AAS_OFF_CMD) & w_strb_reg[0] & w_data_reg[`AAS_CMD_DISARM];
	assign cmd_host   = wr_fire & (aw_addr_reg == `AAS_OFF_CMD) & w_strb_reg[0] & w_data_reg[`AAS_CMD_HOSTTRIG];
	// ****************************************
	// axi4-lite slave
	// ****************************************
	always_comb begin
		ctrl_next = ctrl_reg;
		fcount_next = fcount_reg;
		setup_next = setup_reg;
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (clk_en) begin
			if (s_axi_awvalid && !aw_got_reg) begin
				aw_got_next = 1'b1;
				aw_addr_next = s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got_reg) begin
				w_got_next = 1'b1;
				w_data_next = s_axi_wdata;
				w_strb_next = s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_next = 1'b1;
				bresp_next = `AAS_RESP_OKAY;
				aw_got_next = 1'b0;
				w_got_next = 1'b0;
				unique case (aw_addr_reg)
					`AAS_OFF_CTRL: begin
						if (w_strb_reg[0]) begin
							ctrl_next = w_data_reg[4:0];
						end
					end
					`AAS_OFF_FCOUNT: begin
						if (w_strb_reg[0]) fcount_next[7:0] = w_data_reg[7:0];
						if (w_strb_reg[1]) fcount_next[15:8] = w_data_reg[15:8];
					end
					`AAS_OFF_SETUP: begin
						if (w_strb_reg[0]) setup_next[7:0] = w_data_reg[7:0];
						if (w_strb_reg[1]) setup_next[15:8] = w_data_reg[15:8];
					end
					`AAS_OFF_CMD, `AAS_OFF_STATUS: begin
					end
					default: bresp_next = `AAS_RESP_SLVERR;
				endcase
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_next = 1'b0;
			end
			if (s_axi_arvalid && !rvalid_reg) begin
				rvalid_next = 1'b1;
				rresp_next = `AAS_RESP_OKAY;
				unique case (s_axi_araddr)
					`AAS_OFF_CTRL:   rdata_next = {27'h0, ctrl_reg};
					`AAS_OFF_CMD:    rdata_next = 32'h0;
					`AAS_OFF_FCOUNT: rdata_next = {16'h0, fcount_reg};
					`AAS_OFF_SETUP:  rdata_next = {16'h0, setup_reg};
					`AAS_OFF_STATUS: rdata_next = {fdone_reg, 8'h0, 1'b0, armed_reg, fv_reg,
						2'b0, 3'(st_reg)};
					default: begin
						rdata_next = 32'h0;
						rresp_next = `AAS_RESP_SLVERR;
					end
				endcase
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_next = 1'b0;
			end
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= `AAS_CTRL_RST;
			fcount_reg <= `AAS_FCOUNT_RST;
			setup_reg <= `AAS_SETUP_RST;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'b00;
			rdata_reg <= 32'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			fcount_reg <= fcount_next;
			setup_reg <= setup_next;
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end
	// ****************************************
	// acquisition sequencer
	// ****************************************
	always_comb begin
		st_next = st_reg;
		fdone_next = fdone_reg;
		setup_cnt_next = setup_cnt_reg;
		stop_pend_next = stop_pend_reg;
		fv_next = fv_reg;
		lx_next = lx_reg;
		pf_next = pf_reg;
		armed_next = armed_reg;
		if (clk_en) begin
			lx_next = 1'b0;
			pf_next = 1'b0;
			unique case (st_reg)
				aas_pkg::aas_idle: begin
					fdone_next = 16'h0;
					armed_next = 1'b0;
					fv_next = 1'b0;
					if (cmd_arm) begin
						armed_next = 1'b1;
						setup_cnt_next = setup_reg;
						if (one_image) begin
							st_next = aas_pkg::aas_setup;
						end else if (use_trig) begin
							st_next = aas_pkg::aas_wait_arm;
						end else begin
							st_next = aas_pkg::aas_wait_frame;
						end
					end
				end
				aas_pkg::aas_setup: begin
					// the setup pause costs frame rate but is what single shots need
					if (cmd_disarm) begin
						st_next = aas_pkg::aas_idle;
					end else if (setup_cnt_reg == 16'h0) begin
						st_next = aas_pkg::aas_wait_frame;
					end else begin
						setup_cnt_next = setup_cnt_reg - 16'h1;
					end
				end
				aas_pkg::aas_wait_arm: begin
					// frame start triggers are dropped here
					if (cmd_disarm) begin
						st_next = aas_pkg::aas_idle;
						fdone_next = 16'h0;
					end else if (arm_trig) begin
						st_next = aas_pkg::aas_wait_frame;
						fdone_next = 16'h0;
					end
				end
				aas_pkg::aas_wait_frame: begin
					if (cmd_disarm) begin
						st_next = aas_pkg::aas_idle;
						fdone_next = 16'h0;
					end else if (frame_start_trig) begin
						st_next = aas_pkg::aas_wait_line;
						fv_next = 1'b1;
						fdone_next = fdone_reg + 16'h1;
					end
				end
				aas_pkg::aas_wait_line: begin
					if (cmd_disarm) begin
						pf_next = 1'b1;
						fv_next = 1'b0;
						st_next = aas_pkg::aas_idle;
					end else if (frame_lines_done) begin
						fv_next = 1'b0;
						if (one_image) begin
							st_next = aas_pkg::aas_idle;
						end else if (use_trig && fdone_reg >= fcount_eff) begin
							st_next = aas_pkg::aas_wait_arm;
						end else begin
							st_next = aas_pkg::aas_wait_frame;
						end
					end else if (line_start_trig && fv_reg) begin
						lx_next = 1'b1;
						st_next = aas_pkg::aas_exposing;
					end
				end
				aas_pkg::aas_exposing: begin
					if (cmd_disarm) begin
						stop_pend_next = 1'b1;
					end
					if (line_done) begin
						if (stop_pend_reg || cmd_disarm) begin
							pf_next = 1'b1;
							fv_next = 1'b0;
							stop_pend_next = 1'b0;
							st_next = aas_pkg::aas_idle;
						end else begin
							st_next = aas_pkg::aas_wait_line;
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= aas_pkg::aas_idle;
			fdone_reg <= 16'h0;
			setup_cnt_reg <= 16'h0;
			stop_pend_reg <= 1'b0;
			fv_reg <= 1'b0;
			lx_reg <= 1'b0;
			pf_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			fdone_reg <= fdone_next;
			setup_cnt_reg <= setup_cnt_next;
			stop_pend_reg <= stop_pend_next;
			fv_reg <= fv_next;
			lx_reg <= lx_next;
			pf_reg <= pf_next;
			armed_reg <= armed_next;
		end
	end
	assign frame_valid = fv_reg;
	assign line_expose_start = lx_reg;
	assign partial_frame_send = pf_reg;
	assign armed = armed_reg;
	assign s_axi_awready = ~aw_got_reg & clk_en;
	assign s_axi_wready = ~w_got_reg & clk_en;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ~rvalid_reg & clk_en;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
endmodule

// >>> aas_params.svh
`ifndef AAS_PARAMS_SVH
`define AAS_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define AAS_OFF_CTRL      8'h00
`define AAS_OFF_CMD       8'h04
`define AAS_OFF_FCOUNT    8'h08
`define AAS_OFF_STATUS    8'h0c
`define AAS_OFF_SETUP     8'h10
// ****************************************
// ctrl field positions
// ****************************************
`define AAS_CTRL_STYLE    0
`define AAS_CTRL_USE      1
`define AAS_CTRL_ORG_LO   2
`define AAS_CTRL_ORG_HI   3
`define AAS_CTRL_EDGE     4
// ****************************************
// command bits (write one to fire)
// ****************************************
`define AAS_CMD_ARM       0
`define AAS_CMD_DISARM    1
`define AAS_CMD_HOSTTRIG  2
// ****************************************
// reset values and response codes
// ****************************************
`define AAS_CTRL_RST      5'h00
`define AAS_FCOUNT_RST    16'h0001
`define AAS_SETUP_RST     16'h0010
`define AAS_RESP_OKAY     2'b00
`define AAS_RESP_SLVERR   2'b10
`endif

// >>> aas_pkg.sv
package aas_pkg;
	typedef enum logic [1:0] {
		aas_org_host,
		aas_org_line1,
		aas_org_line2,
		aas_org_line3
	} aas_origin_t;
	typedef enum {
		aas_idle,
		aas_setup,
		aas_wait_arm,
		aas_wait_frame,
		aas_wait_line,
		aas_exposing
	} aas_state_t;
endpackage

// >>> aas_edge_if.sv
`timescale 1ns/1ps
interface aas_edge_if;
	logic [1:0] origin;
	logic       falling;
	logic       fire;
	modport det (input origin, input falling, output fire);
	modport use_side (output origin, output falling, input fire);
endinterface

// >>> aas_edge_det.sv
`timescale 1ns/1ps
module aas_edge_det (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic [2:0] line_in,
	aas_edge_if.det         eif
);
	// ****************************************
	// two-stage sync per line, then edge
	// ****************************************
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] s3_reg;
	logic [2:0] s1_next;
	logic [2:0] s2_next;
	logic [2:0] s3_next;
	logic [2:0] rise;
	logic [2:0] fall;
	logic       fire_next;
	logic       fire_reg;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_line
			assign rise[g] = s2_reg[g] & ~s3_reg[g];
			assign fall[g] = ~s2_reg[g] & s3_reg[g];
		end
	endgenerate
	always_comb begin
		s1_next = s1_reg;
		s2_next = s2_reg;
		s3_next = s3_reg;
		fire_next = fire_reg;
		if (clk_en) begin
			s1_next = line_in;
			s2_next = s1_reg;
			s3_next = s2_reg;
			fire_next = 1'b0;
			if (eif.origin != 2'd0) begin
				fire_next = eif.falling ? fall[eif.origin - 2'd1] : rise[eif.origin - 2'd1];
			end
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
			s3_reg <= 3'h0;
			fire_reg <= 1'b0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			fire_reg <= fire_next;
		end
	end
	assign eif.fire = fire_reg;
endmodule

// >>> aas_seq_checker.sv
`timescale 1ns/1ps
// ****
// sequencer port checks
// ****
module aas_seq_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic frame_start_trig,
	input wire logic line_start_trig,
	input wire logic line_done,
	input wire logic frame_lines_done,
	input wire logic frame_valid,
	input wire logic line_expose_start,
	input wire logic partial_frame_send,
	input wire logic armed
);
	logic busy_reg;
	logic busy_next;
	// a stop must never cut an exposure short, so track one from start to done
	always_comb begin
		busy_next = busy_reg;
		if (line_done) busy_next = 1'h0;
		if (line_expose_start) busy_next = 1'h1;
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) busy_reg <= 1'h0;
		else busy_reg <= busy_next;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// a start pulse or a frame end in the same cycle leaves no room for a new line
	sequence line_req;
		line_start_trig && frame_valid && !busy_reg && !line_expose_start && !frame_lines_done;
	endsequence
	sequence line_go;
		##1 line_expose_start;
	endsequence
	chk_line_taken: assert property (line_req |-> line_go)
		else $error("line start not taken");
	chk_expose_cause: assert property (line_expose_start |-> $past(line_start_trig) && $past(frame_valid))
		else $error("exposure without valid line start");
	chk_line_gated: assert property (line_start_trig && !frame_valid |=> !line_expose_start)
		else $error("line start taken while frame invalid");
	chk_expose_once: assert property (line_expose_start |=> !line_expose_start [*2])
		else $error("exposure pulse repeated");
	chk_fv_cause: assert property ($rose(frame_valid) |-> $past(frame_start_trig) && $past(armed))
		else $error("frame valid without armed frame start");
	chk_fv_drop: assert property ($fell(frame_valid) |-> $past(frame_lines_done) || partial_frame_send)
		else $error("frame valid dropped early");
	chk_partial_idle: assert property (partial_frame_send |=> !armed && !frame_valid)
		else $error("still armed after partial frame");
	chk_partial_after: assert property (partial_frame_send |-> !busy_reg)
		else $error("partial frame during exposure");
endmodule
bind aas_sequencer aas_seq_checker chk_i (.clk_sys, .sys_rst, .frame_start_trig, .line_start_trig, .line_done,
	.frame_lines_done, .frame_valid, .line_expose_start, .partial_frame_send, .armed);

// >>> aas_far_model.sv
`timescale 1ns/1ps
// ****
// downstream line and frame logic
// ****
module aas_far_model #(
	parameter int LINES = 2
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic line_expose_start,
	input  wire logic partial_frame_send,
	input  wire logic slow,
	output logic      line_done,
	output logic      frame_lines_done
);
	int dly;
	int lines;
	// slow stretches the exposure so a stop can land mid-line
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dly <= 0;
			lines <= 0;
			line_done <= 1'h0;
			frame_lines_done <= 1'h0;
		end else begin
			line_done <= (dly == 1);
			frame_lines_done <= line_done && lines == LINES;
			dly <= line_expose_start ? (slow ? 20 : 3) : (dly > 0 ? dly - 1 : 0);
			if (partial_frame_send || frame_lines_done) lines <= 0;
			else if (dly == 1) lines <= lines + 1;
		end
	end
endmodule

// >>> test_acquisition_arm_sequencer.sv
`timescale 1ns/1ps
`include "aas_params.svh"
module test_acquisition_arm_sequencer;
	logic        clk_sys = 1'h0;
	logic        sys_rst = 1'h1;
	logic [2:0]  trig_line_in = 3'h0;
	logic        frame_start_trig = 1'h0;
	logic        line_start_trig = 1'h0;
	logic        slow = 1'h0;
	logic        clk_en = 1'h1;
	logic        line_done, frame_lines_done, frame_valid, line_expose_start, partial_frame_send, armed;
	logic [7:0]  s_axi_awaddr = 8'h0;
	logic [7:0]  s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd_q;
	int          bad_count = 0;
	int          samples_checked = 0;
	always #25 clk_sys = ~clk_sys;
	aas_sequencer dut (.clk_sys, .sys_rst, .clk_en, .trig_line_in, .frame_start_trig, .line_start_trig,
		.line_done, .frame_lines_done, .frame_valid, .line_expose_start, .partial_frame_send, .armed,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	aas_far_model #(.LINES(2)) far (.clk_sys, .sys_rst, .line_expose_start, .partial_frame_send, .slow,
		.line_done, .frame_lines_done);
	// ****
	// shared tasks
	// ****
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wt(ref logic s, input string n);
		for (int i = 0; i < 60 && s !== 1'h1; i++) @(posedge clk_sys);
		chk(n, s, 1'h1);
	endtask
	// ls picks the line start strobe, otherwise the frame start strobe
	task automatic pulse(input bit ls);
		@(posedge clk_sys);
		if (ls) line_start_trig <= 1'h1;
		else frame_start_trig <= 1'h1;
		@(posedge clk_sys);
		line_start_trig <= 1'h0;
		frame_start_trig <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		// no answer time is assumed: only the watchdog ends a hung wait
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("bvalid", s_axi_bvalid, 1'h1);
		chk("bresp", s_axi_bresp, `AAS_RESP_OKAY);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		rd_q = s_axi_rdata;
		chk(n, rd_q & m, e);
	endtask
	task automatic cmd(input logic [31:0] b);
		wr(`AAS_OFF_CMD, b);
	endtask
	task automatic do_frame;
		pulse(1'h0);
		repeat (2) begin
			pulse(1'h1);
			wt(line_expose_start, "expose_start");
			chk("frame_valid", frame_valid, 1'h1);
			wt(line_done, "line_done");
		end
		wt(frame_lines_done, "frame_done");
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		rdc(`AAS_OFF_CTRL, 32'h1f, 32'h0, "ctrl");
		rdc(`AAS_OFF_FCOUNT, 32'hffff, 32'h1, "fcount");
		rdc(`AAS_OFF_SETUP, 32'hffff, 32'h10, "setup");
		rdc(8'h40, 32'hffffffff, 32'h0, "unmapped");
		chk("rresp", s_axi_rresp, `AAS_RESP_SLVERR);
		pulse(1'h0);
		pulse(1'h1);
		chk("armed_rst", armed, 1'h0);
		rdc(`AAS_OFF_STATUS, 32'h67, 32'h0, "idle_no_arm");
		wr(`AAS_OFF_FCOUNT, 32'hffff);
		rdc(`AAS_OFF_FCOUNT, 32'hffff, 32'hffff, "fcount_max");
		$display("t_reset done");
	endtask
	task automatic t_one;
		wr(`AAS_OFF_SETUP, 32'h14);
		wr(`AAS_OFF_CTRL, 32'h0);
		cmd(32'h1);
		rdc(`AAS_OFF_STATUS, 32'h7, 32'h1, "setup_state");
		repeat (25) @(posedge clk_sys);
		rdc(`AAS_OFF_STATUS, 32'h7, 32'h3, "one_ready");
		do_frame;
		rdc(`AAS_OFF_STATUS, 32'h67, 32'h0, "self_disarm");
		chk("armed_one", armed, 1'h0);
		pulse(1'h0);
		rdc(`AAS_OFF_STATUS, 32'h27, 32'h0, "no_second");
		$display("t_one done");
	endtask
	task automatic t_rep;
		wr(`AAS_OFF_CTRL, 32'h1);
		cmd(32'h1);
		rdc(`AAS_OFF_STATUS, 32'h7, 32'h3, "rep_armed");
		do_frame;
		do_frame;
		rdc(`AAS_OFF_STATUS, 32'h67, 32'h43, "rep_stays");
		chk("armed_rep", armed, 1'h1);
		// a frame start while the enable is low must leave every state untouched
		clk_en <= 1'h0;
		pulse(1'h0);
		clk_en <= 1'h1;
		rdc(`AAS_OFF_STATUS, 32'h67, 32'h43, "frozen");
		cmd(32'h2);
		rdc(`AAS_OFF_STATUS, 32'hffff0067, 32'h0, "wait_disarm");
		cmd(32'h1);
		pulse(1'h0);
		cmd(32'h2);
		wt(partial_frame_send, "partial_line_wait");
		cmd(32'h1);
		slow <= 1'h1;
		pulse(1'h0);
		pulse(1'h1);
		cmd(32'h2);
		wt(partial_frame_send, "partial_exposing");
		slow <= 1'h0;
		rdc(`AAS_OFF_STATUS, 32'h67, 32'h0, "stopped");
		pulse(1'h0);
		rdc(`AAS_OFF_STATUS, 32'h27, 32'h0, "stop_holds");
		$display("t_rep done");
	endtask
	task automatic t_trig;
		logic e;
		wr(`AAS_OFF_FCOUNT, 32'h2);
		for (int o = 0; o < 4; o++) begin
			e = (o == 2);
			trig_line_in <= {3{e}};
			wr(`AAS_OFF_CTRL, 32'({e, 2'(o), 2'h3}));
			cmd(32'h1);
			rdc(`AAS_OFF_STATUS, 32'h7, 32'h2, "wait_arm");
			pulse(1'h0);
			rdc(`AAS_OFF_STATUS, 32'h27, 32'h2, "fs_ignored");
			if (o == 0) cmd(32'h4);
			else begin
				@(posedge clk_sys);
				trig_line_in[o-1] <= ~e;
			end
			repeat (8) @(posedge clk_sys);
			rdc(`AAS_OFF_STATUS, 32'h7, 32'h3, "arm_trig");
			do_frame;
			rdc(`AAS_OFF_STATUS, 32'hffff0007, 32'h10003, "one_counted");
			do_frame;
			rdc(`AAS_OFF_STATUS, 32'h7, 32'h2, "count_done");
			cmd(32'h2);
			rdc(`AAS_OFF_STATUS, 32'hffff0007, 32'h0, "disarm_clear");
		end
		$display("t_trig done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'h0;
		t_reset;
		t_one;
		t_rep;
		t_trig;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		final_report;
	end
endmodule
